/* mlgc_pkg.sv */
// Constants for the matrix LED global control register group.
// Assumes a byte-wide register port driven by a serial front end on I_CLK.
package mlgc_pkg;
  // Register offsets
  localparam logic [7:0] ADDR_GLOBAL_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_GLOBAL_CURRENT = 8'h01;
  localparam logic [7:0] ADDR_DEGHOST_CONTROL = 8'h02;
  localparam logic [7:0] ADDR_FAULT_FIRST = 8'h03;
  localparam logic [7:0] ADDR_FAULT_LAST = 8'h26;
  localparam logic [7:0] ADDR_OVERTEMP_CONTROL = 8'h27;
  localparam logic [7:0] ADDR_SPREAD_CONTROL = 8'h28;
  localparam logic [7:0] ADDR_PWM_CLOCK_CONTROL = 8'h29;
  // Reset values
  localparam logic [7:0] RST_GLOBAL_CONTROL = 8'hb0;
  localparam logic [7:0] RST_GLOBAL_CURRENT = 8'h00;
  localparam logic [7:0] RST_DEGHOST_CONTROL = 8'h44;
  localparam logic [7:0] RST_ZERO = 8'h00;
  // Writable masks and the fault read mask, the rest is read-only or reserved
  localparam logic [7:0] WMASK_GLOBAL_CONTROL = 8'hff;
  localparam logic [7:0] WMASK_DEGHOST_CONTROL = 8'h8f;
  localparam logic [7:0] WMASK_OVERTEMP_CONTROL = 8'h6f;
  localparam logic [7:0] WMASK_SPREAD_CONTROL = 8'hdf;
  localparam logic [7:0] WMASK_PWM_CLOCK_CONTROL = 8'he3;
  localparam logic [7:0] FAULT_MASK = 8'h3f;
  // Field positions
  localparam int SW_COUNT_LSB = 4;
  localparam int DETECT_LSB = 1;
  localparam int CHIP_EN_BIT = 0;
  localparam int PULLUP_DIS_BIT = 7;
  localparam int PD_MODE_BIT = 3;
  localparam int PD_STRENGTH_LSB = 0;
  localparam int OT_FLAG_BIT = 7;
  localparam int OT_PROT_DIS_BIT = 6;
  localparam int OT_DET_DIS_BIT = 5;
  localparam int ROLLOFF_FLAG_BIT = 4;
  localparam int ROLLOFF_TH_LSB = 2;
  localparam int ROLLOFF_PCT_LSB = 0;
  localparam int CLK_OUT_EN_BIT = 7;
  localparam int CLK_SEL_BIT = 6;
  localparam int SPREAD_EN_BIT = 4;
  localparam int SPREAD_RANGE_LSB = 2;
  localparam int SPREAD_PERIOD_LSB = 0;
  localparam int PWM_RATE_LSB = 5;
  localparam int PHASE_LSB = 0;
  // Matrix geometry
  localparam int NUM_SWITCH = 12;
  localparam int NUM_SINK = 18;
  localparam int NUM_FAULT_REGS = 36;
  localparam int FAULT_PER_REG = 6;
  // Mode encodings
  typedef enum logic [1:0] {MLGC_DET_OFF, MLGC_DET_SHORT, MLGC_DET_OPEN} mlgc_detect_t;
  typedef enum logic [1:0] {MLGC_PH_DELAY, MLGC_PH_INVERT, MLGC_PH_THREE} mlgc_phase_t;
  localparam logic [1:0] DET_CODE_SHORT = 2'h2;
  localparam logic [1:0] DET_CODE_OPEN = 2'h3;
  localparam logic [2:0] PWM_RATE_UNDEF = 3'h6;
  localparam logic [2:0] PD_STRENGTH_OFF = 3'h0;
endpackage : mlgc_pkg

/* mlgc_sync.sv */
// Two-flop synchroniser for levels from pins or the analog side.
// Assumes the destination clock is I_CLK of the register group.
`timescale 1ns/10ps
`default_nettype none
module mlgc_sync #(
  parameter int WIDTH = 1
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);
  // Both stages held in one state record
  typedef struct packed {
    logic [WIDTH-1:0] meta; // First stage, read only by second
    logic [WIDTH-1:0] stable; // Second stage
  } mlgc_sync_t;
  mlgc_sync_t st;
  mlgc_sync_t next_st;

  // Shift one stage per clock
  always_comb begin
    next_st = st;
    next_st.meta = i_async;
    next_st.stable = st.meta;
  end

  // Clear to zero under reset
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign o_sync = st.stable;
endmodule // mlgc_sync
`default_nettype wire

/* mlgc_regs.sv */
// Global control and protection register group of the matrix LED driver.
// Assumes a serial front end presents single-cycle byte reads and writes,
// and that analog events arrive as asynchronous levels needing sync.
`timescale 1ns/10ps
`default_nettype none
module mlgc_regs #(
  parameter int NUM_SW = mlgc_pkg::NUM_SWITCH, // Switch lines in the matrix
  parameter int NUM_FR = mlgc_pkg::NUM_FAULT_REGS // Fault status registers
) (
  input wire logic I_CLK,
  input wire logic I_RESETN,
  // Register port from the serial front end
  input wire logic i_wr_en, // Write strobe, one cycle
  input wire logic i_rd_en, // Read strobe, one cycle
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wr_data,
  // Sensor levels and same-clock detection results
  input wire logic i_overtemp_event, // Async level from thermal sensor
  input wire logic i_rolloff_active, // Async level, roll-off in effect
  input wire logic i_fault_valid, // Same-clock detection result strobe
  input wire logic [5:0] i_fault_index, // Which status register
  input wire logic [5:0] i_fault_bits, // Faults found for six LEDs
  // Register read answer
  output logic [7:0] o_rd_data, // Read data, valid cycle after strobe
  output logic o_rd_valid,
  // Decoded controls for the matrix, PWM and clock blocks
  output logic [11:0] o_switch_enable, // Lines allowed to scan
  output logic o_scan_run, // Scanning and PWM allowed
  output logic [1:0] o_detect_mode, // mlgc_detect_t code
  output logic [7:0] o_global_current_code,
  output logic o_column_pullup_en,
  output logic o_pulldown_timing_mode,
  output logic [2:0] o_pulldown_strength,
  output logic o_pulldown_en,
  output logic [1:0] o_rolloff_threshold,
  output logic [1:0] o_rolloff_percentage,
  output logic o_clock_out_enable,
  output logic o_clock_source_select,
  output logic o_spread_enable,
  output logic [1:0] o_spread_range,
  output logic [1:0] o_spread_period,
  output logic [2:0] o_pwm_rate_select,
  output logic o_pwm_rate_invalid,
  output logic [1:0] o_phase_mode // mlgc_phase_t code
);

  // Whole module state in one record
  // One process builds next_st and one registers it, so every output
  // is a flop bit or a slice of one and cannot glitch between edges.
  // The cost: derived controls are rebuilt from next_st, which makes
  // the combinational path a little longer.
  typedef struct packed {
    logic [7:0] global_control;
    logic [7:0] global_current;
    logic [7:0] deghost_control;
    logic [7:0] overtemp_control;
    logic [7:0] spread_control;
    logic [7:0] pwm_clock_control;
    logic [NUM_FR*8-1:0] fault_bank; // Flattened status registers
    logic [7:0] rd_data;
    logic rd_valid;
    logic [11:0] switch_enable;
    logic scan_run;
    logic [1:0] detect_mode;
    logic pulldown_en;
    logic pullup_en; // Column pull-ups connected
    logic pwm_rate_invalid;
    logic [1:0] phase_mode;
    logic ot_seen; // Previous synced event level
  } mlgc_state_t;

  // Current and next copies of the record
  mlgc_state_t st;
  mlgc_state_t next_st;
  logic [1:0] synced; // Overtemp and roll-off after two flops

  // Analog levels cross into the clock domain here
  // Thermal levels bear no relation to I_CLK, so both pass two
  // flops before any logic reads them.
  // Latency is two edges, plus one for the event edge detector.
  mlgc_sync #(
    .WIDTH(2)
  ) u_sync (
    .i_clk(I_CLK),
    .i_resetn(I_RESETN),
    .i_async({i_rolloff_active, i_overtemp_event}),
    .o_sync(synced)
  );

  // Lines 1..n+1 enabled; codes above 11 saturate to all lines
  // The loop follows the line count parameter, so codes past the
  // last line can never light a line that does not exist.
  // Only the derived switch mask uses it.
  function automatic logic [11:0] switch_mask(input logic [3:0] code);
    logic [11:0] m;
    m = '0;
    for (int i = 0; i < NUM_SW; i++) begin
      if (i <= int'(code)) begin
        m[i] = 1'b1;
      end
    end
    return m;
  endfunction

  // Decode the two-bit detection field
  // Upper bit clear means off whatever the lower bit holds;
  // the output never takes the unused fourth code.
  function automatic logic [1:0] detect_decode(input logic [1:0] code);
    logic [1:0] r;
    r = 2'(mlgc_pkg::MLGC_DET_OFF);
    if (code == mlgc_pkg::DET_CODE_SHORT) begin
      r = 2'(mlgc_pkg::MLGC_DET_SHORT);
    end else if (code == mlgc_pkg::DET_CODE_OPEN) begin
      r = 2'(mlgc_pkg::MLGC_DET_OPEN);
    end
    return r;
  endfunction

  // Merge a write under its writable mask
  // Bits outside the mask keep their old value, which is how
  // read-only flags and reserved bits survive a host write.
  // Shared by all masked registers.
  function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] wd,
                                       input logic [7:0] mask);
    return (old & ~mask) | (wd & mask);
  endfunction

  // Next-state logic for registers, status and derived outputs
  // Order matters: host writes first, then hardware events, so an
  // event in the same cycle overrides the host. Derived outputs
  // come last, built from next_st.
  always_comb begin
    logic ot_rise;
    logic [7:0] rd;
    ot_rise = 1'b0;
    rd = mlgc_pkg::RST_ZERO;
    next_st = st;
    next_st.ot_seen = synced[0];
    ot_rise = synced[0] && !st.ot_seen;

    // Host writes; read-only bits keep hardware values
    // Only the addressed register changes; a strobe held high
    // would simply write the same byte again.
    if (i_wr_en) begin
      unique case (i_addr)
        mlgc_pkg::ADDR_GLOBAL_CONTROL: begin
          next_st.global_control = merge(st.global_control, i_wr_data,
                                         mlgc_pkg::WMASK_GLOBAL_CONTROL);
        end
        mlgc_pkg::ADDR_GLOBAL_CURRENT: begin
          next_st.global_current = i_wr_data;
        end
        mlgc_pkg::ADDR_DEGHOST_CONTROL: begin
          next_st.deghost_control = merge(st.deghost_control, i_wr_data,
                                          mlgc_pkg::WMASK_DEGHOST_CONTROL);
        end
        mlgc_pkg::ADDR_OVERTEMP_CONTROL: begin
          next_st.overtemp_control = merge(st.overtemp_control, i_wr_data,
                                           mlgc_pkg::WMASK_OVERTEMP_CONTROL);
        end
        mlgc_pkg::ADDR_SPREAD_CONTROL: begin
          next_st.spread_control = merge(st.spread_control, i_wr_data,
                                         mlgc_pkg::WMASK_SPREAD_CONTROL);
        end
        mlgc_pkg::ADDR_PWM_CLOCK_CONTROL: begin
          next_st.pwm_clock_control = merge(st.pwm_clock_control, i_wr_data,
                                            mlgc_pkg::WMASK_PWM_CLOCK_CONTROL);
        end
        default: begin
          // Fault bank and unmapped: write dropped
        end
      endcase
    end

    // Over-temperature: flag set when detection on, sticky until reset
    // The event is the rising edge of the synced level, so a sensor
    // that stays hot raises one event; it must fall and rise again.
    // The flag has no software clear, only reset removes it.
    if (ot_rise && !st.overtemp_control[mlgc_pkg::OT_DET_DIS_BIT]) begin
      next_st.overtemp_control[mlgc_pkg::OT_FLAG_BIT] = 1'b1;
    end
    // Protection wins over a same-cycle host enable
    // With protection disabled the chip keeps running hot; the
    // flag still tells the host what happened.
    if (ot_rise && !st.overtemp_control[mlgc_pkg::OT_PROT_DIS_BIT]) begin
      next_st.global_control[mlgc_pkg::CHIP_EN_BIT] = 1'b0;
    end
    // Roll-off status tracks the synced level
    // The host cannot write it; this assignment follows the host write and overrides bit four.
    next_st.overtemp_control[mlgc_pkg::ROLLOFF_FLAG_BIT] = synced[1];

    // Detection results land in the fault bank
    // Indices past the last register are dropped, never wrapped,
    // so a stray index cannot corrupt a neighbour.
    if (i_fault_valid && (int'(i_fault_index) < NUM_FR)) begin
      next_st.fault_bank[int'(i_fault_index)*8 +: 8] =
        {2'b00, i_fault_bits};
    end

    // Read mux; reserved bits come from reset values held in registers
    // The mux sees values from before this edge, so a read and a
    // write to one offset in one cycle return the old byte.
    // Read data holds until the next read; valid pulses once.
    if (i_addr >= mlgc_pkg::ADDR_FAULT_FIRST && i_addr <= mlgc_pkg::ADDR_FAULT_LAST) begin
      rd = st.fault_bank[(int'(i_addr) - int'(mlgc_pkg::ADDR_FAULT_FIRST))*8 +: 8]
           & mlgc_pkg::FAULT_MASK;
    end else begin
      unique case (i_addr)
        mlgc_pkg::ADDR_GLOBAL_CONTROL: rd = st.global_control;
        mlgc_pkg::ADDR_GLOBAL_CURRENT: rd = st.global_current;
        mlgc_pkg::ADDR_DEGHOST_CONTROL: rd = st.deghost_control;
        mlgc_pkg::ADDR_OVERTEMP_CONTROL: rd = st.overtemp_control;
        mlgc_pkg::ADDR_SPREAD_CONTROL: rd = st.spread_control;
        mlgc_pkg::ADDR_PWM_CLOCK_CONTROL: rd = st.pwm_clock_control;
        default: rd = mlgc_pkg::RST_ZERO; // Unmapped reads zero
      endcase
    end
    next_st.rd_valid = i_rd_en;
    if (i_rd_en) begin
      next_st.rd_data = rd;
    end

    // Derived controls are built from next_st, so they change on the
    // same edge as the register they come from, with no extra lag.
    // Chip enable low forces every switch line off, whatever the count.
    next_st.scan_run = next_st.global_control[mlgc_pkg::CHIP_EN_BIT];
    if (next_st.scan_run) begin
      next_st.switch_enable = switch_mask(
        next_st.global_control[mlgc_pkg::SW_COUNT_LSB +: 4]);
    end else begin
      next_st.switch_enable = '0;
    end
    next_st.detect_mode = detect_decode(
      next_st.global_control[mlgc_pkg::DETECT_LSB +: 2]);
    next_st.pulldown_en = next_st.deghost_control[mlgc_pkg::PD_STRENGTH_LSB +: 3]
                          != mlgc_pkg::PD_STRENGTH_OFF;
    // Pull-ups connected while the disable bit is clear
    next_st.pullup_en = !next_st.deghost_control[mlgc_pkg::PULLUP_DIS_BIT];
    // Rate code 110 has no defined frequency; flagged, not refused
    next_st.pwm_rate_invalid = next_st.pwm_clock_control[mlgc_pkg::PWM_RATE_LSB +: 3]
                               == mlgc_pkg::PWM_RATE_UNDEF;
    // Upper phase bit set means three-phase whatever the low bit
    if (next_st.pwm_clock_control[mlgc_pkg::PHASE_LSB + 1]) begin
      next_st.phase_mode = 2'(mlgc_pkg::MLGC_PH_THREE);
    end else if (next_st.pwm_clock_control[mlgc_pkg::PHASE_LSB]) begin
      next_st.phase_mode = 2'(mlgc_pkg::MLGC_PH_INVERT);
    end else begin
      next_st.phase_mode = 2'(mlgc_pkg::MLGC_PH_DELAY);
    end
  end

  // Register the state record; async reset to power-up defaults
  // The reset branch loads constants only; derived outputs get the
  // values their registers imply, so nothing jumps at the first edge.
  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      st <= '0;
      st.global_control <= mlgc_pkg::RST_GLOBAL_CONTROL;
      st.global_current <= mlgc_pkg::RST_GLOBAL_CURRENT;
      st.deghost_control <= mlgc_pkg::RST_DEGHOST_CONTROL;
      st.detect_mode <= 2'(mlgc_pkg::MLGC_DET_OFF);
      st.pulldown_en <= 1'b1;
      st.pullup_en <= 1'b1;
      st.phase_mode <= 2'(mlgc_pkg::MLGC_PH_DELAY);
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from the state flops
  // Register port answer
  assign o_rd_data = st.rd_data;
  assign o_rd_valid = st.rd_valid;

  // Scan control
  assign o_switch_enable = st.switch_enable;
  assign o_scan_run = st.scan_run;
  assign o_detect_mode = st.detect_mode;

  // Current and de-ghost settings
  assign o_global_current_code = st.global_current;
  assign o_column_pullup_en = st.pullup_en;
  assign o_pulldown_timing_mode = st.deghost_control[mlgc_pkg::PD_MODE_BIT];
  assign o_pulldown_strength = st.deghost_control[mlgc_pkg::PD_STRENGTH_LSB +: 3];
  assign o_pulldown_en = st.pulldown_en;

  // Thermal roll-off settings
  assign o_rolloff_threshold = st.overtemp_control[mlgc_pkg::ROLLOFF_TH_LSB +: 2];
  assign o_rolloff_percentage = st.overtemp_control[mlgc_pkg::ROLLOFF_PCT_LSB +: 2];

  // Clock and spread-spectrum settings
  assign o_clock_out_enable = st.spread_control[mlgc_pkg::CLK_OUT_EN_BIT];
  assign o_clock_source_select = st.spread_control[mlgc_pkg::CLK_SEL_BIT];
  assign o_spread_enable = st.spread_control[mlgc_pkg::SPREAD_EN_BIT];
  assign o_spread_range = st.spread_control[mlgc_pkg::SPREAD_RANGE_LSB +: 2];
  assign o_spread_period = st.spread_control[mlgc_pkg::SPREAD_PERIOD_LSB +: 2];

  // PWM rate and phase
  assign o_pwm_rate_select = st.pwm_clock_control[mlgc_pkg::PWM_RATE_LSB +: 3];
  assign o_pwm_rate_invalid = st.pwm_rate_invalid;
  assign o_phase_mode = st.phase_mode;
endmodule // mlgc_regs
`default_nettype wire

/* mlgc_regs_props.sv */
// Port-level checker for the global control register group.
// Assumes single-cycle strobes and the timing of the register port contract.
`timescale 1ns/10ps
`default_nettype none
module mlgc_props (
  input wire logic I_CLK,
  input wire logic I_RESETN,
  input wire logic i_wr_en,
  input wire logic i_rd_en,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wr_data,
  input wire logic i_overtemp_event,
  input wire logic [7:0] o_rd_data,
  input wire logic o_rd_valid,
  input wire logic [11:0] o_switch_enable,
  input wire logic o_scan_run,
  input wire logic [1:0] o_detect_mode,
  input wire logic [7:0] o_global_current_code,
  input wire logic o_column_pullup_en,
  input wire logic [2:0] o_pulldown_strength,
  input wire logic o_pulldown_en,
  input wire logic [2:0] o_pwm_rate_select,
  input wire logic o_pwm_rate_invalid,
  input wire logic [1:0] o_phase_mode
);
  // One clock domain, so clocking and reset are given once
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RESETN);
  // Read answers one cycle after the strobe, data holds between reads
  chk_read_answer: assert property (i_rd_en |=> o_rd_valid)
    else $error("read strobe not answered");
  chk_read_hold: assert property (!i_rd_en |=> !o_rd_valid && $stable(o_rd_data))
    else $error("read data moved without a read");
  // Pin low two edges back rules out a protection event at the write edge
  chk_chip_enable_write: assert property (i_wr_en && i_addr == 8'h00 && !i_overtemp_event
    && !$past(i_overtemp_event) && !$past(i_overtemp_event, 2)
    |=> o_scan_run == $past(i_wr_data[0]))
    else $error("chip enable did not follow write");
  chk_current_write: assert property (i_wr_en && i_addr == 8'h01
    |=> o_global_current_code == $past(i_wr_data))
    else $error("global current did not follow write");
  chk_pullup_write: assert property (i_wr_en && i_addr == 8'h02
    |=> o_column_pullup_en == !$past(i_wr_data[7]))
    else $error("pull-up enable wrong after write");
  // While scanning, enabled lines form a run starting at the first line
  chk_switch_run: assert property (o_scan_run |-> o_switch_enable[0]
    && ((o_switch_enable & (o_switch_enable + 12'h001)) == 12'h000))
    else $error("switch lines not contiguous");
  chk_scan_off: assert property (!o_scan_run |-> o_switch_enable == 12'h000)
    else $error("switch lines active while disabled");
  chk_detect_code: assert property (o_detect_mode != 2'h3)
    else $error("illegal detect mode");
  chk_pulldown_off: assert property (o_pulldown_en == (o_pulldown_strength != 3'h0))
    else $error("pull-down enable disagrees with strength");
  chk_rate_invalid: assert property (o_pwm_rate_invalid == (o_pwm_rate_select == 3'h6))
    else $error("undefined rate flag wrong");
  chk_phase_code: assert property (o_phase_mode != 2'h3)
    else $error("illegal phase mode");
  chk_fault_resv: assert property (i_rd_en && i_addr >= 8'h03 && i_addr <= 8'h26
    |=> o_rd_data[7:6] == 2'h0)
    else $error("fault reserved bits not zero");
endmodule // mlgc_props
bind mlgc_regs mlgc_props mlgc_props_inst (.I_CLK, .I_RESETN, .i_wr_en, .i_rd_en, .i_addr,
  .i_wr_data, .i_overtemp_event, .o_rd_data, .o_rd_valid, .o_switch_enable, .o_scan_run,
  .o_detect_mode, .o_global_current_code, .o_column_pullup_en, .o_pulldown_strength,
  .o_pulldown_en, .o_pwm_rate_select, .o_pwm_rate_invalid, .o_phase_mode);
`default_nettype wire

/* mlgc_host.sv */
// Host-side model of the serial front end: single byte writes and reads.
// Assumes the register port takes strobes on the rising edge of i_clk.
`timescale 1ns/10ps
`default_nettype none
module mlgc_host (
  input wire logic i_clk,
  output logic o_wr_en,
  output logic o_rd_en,
  output logic [7:0] o_addr,
  output logic [7:0] o_wr_data,
  input wire logic [7:0] i_rd_data,
  input wire logic i_rd_valid
);
  // Idle bus shows garbage, never a stale valid-looking value
  initial begin
    o_wr_en = 1'b0;
    o_rd_en = 1'b0;
    o_addr = 8'h5a;
    o_wr_data = 8'ha5;
  end
  // Strobe for exactly one rising edge, then scramble the released bus
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge i_clk);
    o_addr = a;
    o_wr_data = d;
    o_wr_en = 1'b1;
    @(negedge i_clk);
    o_wr_en = 1'b0;
    o_addr = ~a;
    o_wr_data = ~d;
  endtask
  // Answer stands in the cycle after the taken edge, sampled mid-cycle
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
    @(negedge i_clk);
    o_addr = a;
    o_rd_en = 1'b1;
    @(negedge i_clk);
    d = i_rd_data;
    v = i_rd_valid;
    o_rd_en = 1'b0;
    o_addr = ~a;
  endtask
endmodule // mlgc_host
`default_nettype wire

/* mlgc_regs_bench.sv */
// Self-checking bench for the global control register group.
// Assumes the host model drives the register port; sensors driven here.
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin err_count++; \
  $display("MISMATCH t=%0t got %h exp %h", $time, (a), (e)); end end
module mlgc_regs_bench;
  logic I_CLK = 1'b0;
  logic I_RESETN = 1'b0;
  logic i_wr_en, i_rd_en, o_rd_valid, o_scan_run, o_column_pullup_en, o_pulldown_en;
  logic o_pulldown_timing_mode, o_clock_out_enable, o_clock_source_select, o_spread_enable;
  logic i_overtemp_event = 1'b0; // Sensors idle at time zero
  logic i_rolloff_active = 1'b0;
  logic i_fault_valid = 1'b0;
  logic [5:0] i_fault_index = 6'h00;
  logic [5:0] i_fault_bits = 6'h00;
  logic [7:0] i_addr, i_wr_data, o_rd_data, o_global_current_code, rv;
  logic [11:0] o_switch_enable;
  logic [1:0] o_detect_mode, o_rolloff_threshold, o_rolloff_percentage, o_spread_range;
  logic [1:0] o_spread_period, o_phase_mode;
  logic [2:0] o_pulldown_strength, o_pwm_rate_select;
  logic o_pwm_rate_invalid, vv;
  int err_count = 0;
  int compares = 0;
  always #2 I_CLK = ~I_CLK;
  mlgc_host mlgc_host_inst (.i_clk(I_CLK), .o_wr_en(i_wr_en), .o_rd_en(i_rd_en),
    .o_addr(i_addr), .o_wr_data(i_wr_data), .i_rd_data(o_rd_data), .i_rd_valid(o_rd_valid));
  mlgc_regs mlgc_regs_inst (.I_CLK, .I_RESETN, .i_wr_en, .i_rd_en, .i_addr, .i_wr_data,
    .i_overtemp_event, .i_rolloff_active, .i_fault_valid, .i_fault_index, .i_fault_bits,
    .o_rd_data, .o_rd_valid, .o_switch_enable, .o_scan_run, .o_detect_mode,
    .o_global_current_code, .o_column_pullup_en, .o_pulldown_timing_mode,
    .o_pulldown_strength, .o_pulldown_en, .o_rolloff_threshold, .o_rolloff_percentage,
    .o_clock_out_enable, .o_clock_source_select, .o_spread_enable, .o_spread_range,
    .o_spread_period, .o_pwm_rate_select, .o_pwm_rate_invalid, .o_phase_mode);
  task automatic end_sim;
    $display("TB counts: err_count %0d compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // Reset held 16 cycles; also reused mid-run
  task automatic do_reset;
    I_RESETN = 1'b0;
    repeat (16) @(negedge I_CLK);
    I_RESETN = 1'b1;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    mlgc_host_inst.rd(a, rv, vv);
    `CHK(vv, 1'b1)
    `CHK(rv, e)
  endtask
  // Reset values, including an unmapped offset that reads zero
  task automatic t_reset;
    logic [7:0] a [9] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h26, 8'h27, 8'h28, 8'h29, 8'h2a};
    logic [7:0] e [9] = '{8'hb0, 8'h00, 8'h44, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    `CHK({o_scan_run, o_pulldown_strength}, 4'h4)
    for (int i = 0; i < 9; i++) rd_chk(a[i], e[i]);
  endtask
  // Status bits land by index; first and last register, out-of-range dropped
  task automatic t_fault;
    @(negedge I_CLK);
    {i_fault_valid, i_fault_index, i_fault_bits} = {1'b1, 6'h00, 6'h2a};
    @(negedge I_CLK);
    {i_fault_index, i_fault_bits} = {6'h23, 6'h3f};
    @(negedge I_CLK);
    {i_fault_index, i_fault_bits} = {6'h24, 6'h15};
    @(negedge I_CLK);
    i_fault_valid = 1'b0;
    rd_chk(8'h03, 8'h2a);
    rd_chk(8'h26, 8'h3f);
    rd_chk(8'h27, 8'h00);
    mlgc_host_inst.wr(8'h03, 8'hff);
    rd_chk(8'h03, 8'h2a);
  endtask
  // All-ones writes expose writable masks, then field outputs
  task automatic t_fields;
    logic [7:0] a [5] = '{8'h01, 8'h02, 8'h27, 8'h28, 8'h29};
    logic [7:0] e [5] = '{8'hff, 8'hcf, 8'h6f, 8'hdf, 8'he3};
    for (int i = 0; i < 5; i++) mlgc_host_inst.wr(a[i], 8'hff);
    for (int i = 0; i < 5; i++) rd_chk(a[i], e[i]);
    `CHK(o_global_current_code, 8'hff)
    `CHK({o_column_pullup_en, o_pulldown_timing_mode}, 2'h1)
    `CHK({o_pulldown_strength, o_pulldown_en}, 4'hf)
    `CHK({o_rolloff_threshold, o_rolloff_percentage}, 4'hf)
    `CHK({o_clock_out_enable, o_clock_source_select, o_spread_enable}, 3'h7)
    `CHK({o_spread_range, o_spread_period}, 4'hf)
    `CHK({o_pwm_rate_select, o_pwm_rate_invalid, o_phase_mode}, 6'h3a)
    mlgc_host_inst.wr(8'h02, 8'h00);
    `CHK({o_column_pullup_en, o_pulldown_timing_mode}, 2'h2)
    `CHK({o_pulldown_strength, o_pulldown_en}, 4'h0)
    rd_chk(8'h02, 8'h40);
    mlgc_host_inst.wr(8'h29, 8'hc1);
    `CHK({o_pwm_rate_select, o_pwm_rate_invalid, o_phase_mode}, 6'h35)
    mlgc_host_inst.wr(8'h29, 8'h20);
    `CHK({o_pwm_rate_select, o_pwm_rate_invalid, o_phase_mode}, 6'h08)
  endtask
  // Every switch count and detect code, then disable stops all lines
  task automatic t_switch;
    for (int n = 0; n < 16; n++) begin
      mlgc_host_inst.wr(8'h00, 8'(n << 4) | 8'h01);
      `CHK(o_switch_enable, (n >= 11) ? 12'hfff : 12'((1 << (n + 1)) - 1))
    end
    for (int c = 0; c < 4; c++) begin
      mlgc_host_inst.wr(8'h00, 8'(c << 1) | 8'h01);
      `CHK(o_detect_mode, (c < 2) ? 2'h0 : 2'(c - 1))
    end
    mlgc_host_inst.wr(8'h00, 8'hb0);
    `CHK({o_scan_run, o_switch_enable}, 13'h0000)
  endtask
  // Thermal events with detect off, then with protection off; flag sticks
  task automatic t_thermal;
    i_rolloff_active = 1'b1;
    do_reset;
    mlgc_host_inst.wr(8'h27, 8'h20);
    mlgc_host_inst.wr(8'h00, 8'h01);
    i_overtemp_event = 1'b1;
    repeat (6) @(negedge I_CLK);
    `CHK({o_scan_run, o_switch_enable}, 13'h0000)
    rd_chk(8'h27, 8'h30);
    i_overtemp_event = 1'b0;
    repeat (4) @(negedge I_CLK);
    mlgc_host_inst.wr(8'h27, 8'h40);
    mlgc_host_inst.wr(8'h00, 8'h01);
    i_overtemp_event = 1'b1;
    repeat (6) @(negedge I_CLK);
    `CHK(o_scan_run, 1'b1)
    rd_chk(8'h27, 8'hd0);
    {i_overtemp_event, i_rolloff_active} = 2'h0;
    repeat (4) @(negedge I_CLK);
    rd_chk(8'h27, 8'hc0);
  endtask
  // Watchdog far beyond the 168 cycles the tests need
  initial begin
    #200000;
    err_count++;
    end_sim;
  end
  initial begin
    do_reset;
    t_reset;
    t_fault;
    t_fields;
    t_switch;
    t_thermal;
    end_sim;
  end
endmodule // mlgc_regs_bench
`default_nettype wire
